// >>> src/plt_pkg.sv
// shared constants, types and carriers of the process loop block
package plt_pkg;

	localparam int              VAL_W       = 16;
	localparam logic [15:0]     FULL_SCALE  = 16'h2710;
	localparam int              CLK_KHZ     = 40000;
	localparam int              TICK_US     = 1000;
	localparam int              TICK_CYC    = (CLK_KHZ * TICK_US + 999) / 1000;
	localparam logic [31:0]     TICKS_PER_S = 32'h0000_03E8;
	localparam int              N_DOUT      = 4;
	localparam logic [2:0]      TUNE_CYCLES = 3'h4;
	localparam logic [2:0]      RESP_MAX    = 3'h4;
	localparam logic [3:0]      RESP_BASE   = 4'h2;
	localparam int              FILT_FRAC   = 8;

	typedef enum logic [1:0] {
		MAP_OFF   = 2'h0,
		MAP_HEAT  = 2'h1,
		MAP_COOL  = 2'h2,
		MAP_ALARM = 2'h3
	} plt_dmap_t;

	typedef enum logic [1:0] {
		SRC_HEAT = 2'h0,
		SRC_COOL = 2'h1,
		SRC_OUT  = 2'h2,
		SRC_PV   = 2'h3
	} plt_asrc_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RUN  = 3'b010,
		ST_DONE = 3'b100
	} plt_tune_st_t;

	typedef struct packed {
		logic alarm_acknowledge_bit;
		logic fault_acknowledge_bit;
		logic autotune_request;
	} plt_host_t;

	typedef struct packed {
		logic autotune_running_ack;
		logic autotune_complete_flag;
		logic autotune_error_flag;
		logic heater_leak_current_alarm;
		logic heater_missing_current_alarm;
		logic input_fault_alarm;
		logic any_process_alarm;
	} plt_stat_t;

	typedef struct packed {
		logic [1:0]  chan;
		logic [15:0] limit_low;
		logic [15:0] limit_high;
		logic        latch;
	} plt_hcm_cfg_t;

	typedef struct packed {
		plt_asrc_t          src;
		logic signed [15:0] drive_min;
		logic signed [15:0] drive_max;
		logic [15:0]        filt_s;
		logic [15:0]        deadband;
		logic [15:0]        upd_ticks;
	} plt_aout_cfg_t;

	localparam plt_stat_t STAT_RST = '0;

endpackage : plt_pkg

// >>> src/plt_tprop.sv
// time-proportioned drive of one discrete output
module plt_tprop
	import plt_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        reset_n_in,
	input  wire logic        tick_in,
	input  wire logic [15:0] cycle_ticks_in,
	input  wire logic [15:0] duty_in,
	output logic             on_out
);

	typedef struct packed {
		logic [15:0] cnt;
		logic        on;
	} plt_tp_st_t;

	plt_tp_st_t s_q;
	plt_tp_st_t s_d;
	logic [31:0] pos;
	logic [31:0] lim;
	logic [15:0] nxt;

	always_comb begin
		s_d = s_q;
		nxt = s_q.cnt + 16'h0001;
		pos = {16'h0000, s_q.cnt} * {16'h0000, FULL_SCALE};
		lim = {16'h0000, duty_in} * {16'h0000, cycle_ticks_in};
		if (tick_in) begin
			s_d.cnt = (nxt >= cycle_ticks_in) ? 16'h0000 : nxt;
		end
		s_d.on = pos < lim;
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign on_out = s_q.on;

endmodule : plt_tprop

// >>> src/plt_aout.sv
// analog output: scaling, first-order filter, deadband and update timer
module plt_aout
	import plt_pkg::*;
(
	input  wire logic               clk_in,
	input  wire logic               reset_n_in,
	input  wire logic               tick_in,
	input  wire logic signed [15:0] value_in,
	input  wire plt_aout_cfg_t      cfg_in,
	output logic [15:0]             aout_out
);

	typedef struct packed {
		logic signed [31:0] acc;
		logic [15:0]        cnt;
		logic [15:0]        out;
	} plt_ao_st_t;

	plt_ao_st_t s_q;
	plt_ao_st_t s_d;
	logic signed [31:0] span;
	logic signed [31:0] sc;
	logic signed [31:0] dn;
	logic signed [31:0] diff;
	logic [15:0]        filt;

	always_comb begin
		s_d  = s_q;
		span = 32'(cfg_in.drive_max) - 32'(cfg_in.drive_min);
		sc   = 32'sh0;
		if (span > 32'sh0) begin
			sc = ((32'(value_in) - 32'(cfg_in.drive_min)) * $signed(32'(FULL_SCALE)))
				/ span;
		end
		if (sc < 32'sh0) begin
			sc = 32'sh0;
		end else if (sc > $signed(32'(FULL_SCALE))) begin
			sc = 32'(FULL_SCALE);
		end
		dn   = $signed({16'h0000, cfg_in.filt_s} * TICKS_PER_S[15:0]) + 32'sh1;
		filt = s_q.acc[FILT_FRAC+15:FILT_FRAC];
		diff = 32'({16'h0000, filt}) - 32'({16'h0000, s_q.out});
		if (diff < 32'sh0) begin
			diff = -diff;
		end
		if (tick_in) begin
			s_d.acc = s_q.acc + ((sc <<< FILT_FRAC) - s_q.acc) / dn;
			if (s_q.cnt + 16'h0001 >= cfg_in.upd_ticks) begin
				s_d.cnt = 16'h0000;
				if ((diff <<< 1) > 32'({16'h0000, cfg_in.deadband})) begin
					s_d.out = filt;
				end
			end else begin
				s_d.cnt = s_q.cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign aout_out = s_q.out;

endmodule : plt_aout

// >>> src/plt_top.sv
// process loop alarms, input fault, outputs and auto-tune handshake
//
// Operation
// - heater alarm judges current against one of four outputs, chosen by config.
// - selected output off and current above low limit raises leak alarm.
// - selected output on and current below high limit raises missing alarm.
// - latched heater alarm stays until host writes one to acknowledge bit.
// - unlatched heater alarm self-clears; acknowledge bit then disables it.
// - sensor failure forces control output to configured substitute value.
// - input fault counts among process alarms for any-alarm outputs.
// - latched fault stays until fault acknowledge; unlatched clears on recovery.
// - analog-mapped digital output is time-proportioned over configured cycle.
// - analog output scaled linearly between drive min and drive max.
// - analog output smoothed by first-order filter, time constant in seconds.
// - analog output holds unless change exceeds half the deadband.
// - at update timer expiry apply value only if deadband passes; restart timer.
// - auto-tune runs on/off control with hysteresis through four cycles.
// - tune target sits 75 percent of way from process value to setpoint.
// - tune response 0..4, very aggressive to very conservative, shapes result.
// - request high starts tune; acknowledge stays high while tuning runs.
// - on request fall, acknowledge, done and failure flags return to zero.
// - tune that cannot finish raises done and failure flags together.
// - quantities are scaled integers; 10000 means one hundred percent.
// - leak and missing heater alarms are reported as separate bits.
module plt_top
	import plt_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC
)
(
	input  wire logic                 clk_in,
	input  wire logic                 reset_n_in,
	input  wire plt_host_t            host_in,
	input  wire plt_hcm_cfg_t         hcm_cfg_in,
	input  wire logic [15:0]          heater_current_in,
	input  wire logic                 input_fault_in,
	input  wire logic                 fault_latch_in,
	input  wire logic signed [15:0]   fault_value_in,
	input  wire logic signed [15:0]   pid_output_in,
	input  wire logic [N_DOUT-1:0]    proc_alarm_in,
	input  wire logic signed [15:0]   pv_in,
	input  wire logic signed [15:0]   setpoint_in,
	input  wire logic [15:0]          onoff_hyst_in,
	input  wire logic [2:0]           tune_response_in,
	input  wire logic [2*N_DOUT-1:0]  dout_map_in,
	input  wire logic [15:0]          cycle_ticks_in,
	input  wire plt_aout_cfg_t        aout_cfg_in,
	output plt_stat_t                 status_out,
	output logic [N_DOUT-1:0]         dout_out,
	output logic signed [15:0]        control_output_out,
	output logic [15:0]               aout_out,
	output logic signed [15:0]        tune_target_out,
	output logic [15:0]               tuned_period_out,
	output logic [15:0]               tuned_pband_out
);

	////////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [15:0]        tick_cnt;
		logic               tick;
		plt_tune_st_t       st;
		plt_stat_t          stat;
		logic signed [15:0] target;
		logic               heat_on;
		logic [2:0]         cyc_cnt;
		logic [15:0]        per_cnt;
		logic [15:0]        period;
		logic signed [15:0] pmax;
		logic signed [15:0] pmin;
		logic [15:0]        pband;
		logic signed [15:0] ctrl;
		logic [N_DOUT-1:0]  dout;
	} plt_top_st_t;

	plt_top_st_t s_q;
	plt_top_st_t s_d;

	logic [N_DOUT-1:0]  tp_on;
	logic [15:0]        heat_pwr;
	logic [15:0]        cool_pwr;
	logic signed [15:0] asrc;
	logic               sel_out;
	logic               leak_cond;
	logic               miss_cond;
	logic               fault_now;
	logic signed [31:0] gap;
	logic               want_on;
	logic [2:0]         resp;
	logic [31:0]        swing;

	////////////////////////////////////////////////////////////////////////////////
	// power split and output mapping

	always_comb begin
		heat_pwr = 16'h0000;
		cool_pwr = 16'h0000;
		if (s_q.ctrl > $signed(FULL_SCALE)) begin
			heat_pwr = FULL_SCALE;
		end else if (s_q.ctrl > 16'sh0) begin
			heat_pwr = s_q.ctrl;
		end
		if (s_q.ctrl < -$signed(FULL_SCALE)) begin
			cool_pwr = FULL_SCALE;
		end else if (s_q.ctrl < 16'sh0) begin
			cool_pwr = 16'(-s_q.ctrl);
		end
	end

	for (genvar i = 0; i < N_DOUT; i++) begin : g_dout
		plt_dmap_t   map;
		logic [15:0] duty;
		assign map  = plt_dmap_t'(dout_map_in[2*i +: 2]);
		assign duty = (map == MAP_COOL) ? cool_pwr : heat_pwr;
		plt_tprop u_tprop (
			.clk_in         (clk_in),
			.reset_n_in     (reset_n_in),
			.tick_in        (s_q.tick),
			.cycle_ticks_in (cycle_ticks_in),
			.duty_in        (duty),
			.on_out         (tp_on[i])
		);
	end

	always_comb begin
		case (aout_cfg_in.src)
			SRC_HEAT: begin
				asrc = $signed(heat_pwr);
			end
			SRC_COOL: begin
				asrc = $signed(cool_pwr);
			end
			SRC_OUT: begin
				asrc = s_q.ctrl;
			end
			default: begin
				asrc = pv_in;
			end
		endcase
	end

	plt_aout u_aout (
		.clk_in     (clk_in),
		.reset_n_in (reset_n_in),
		.tick_in    (s_q.tick),
		.value_in   (asrc),
		.cfg_in     (aout_cfg_in),
		.aout_out   (aout_out)
	);

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_d = s_q;

		// control tick
		s_d.tick = 1'b0;
		if (s_q.tick_cnt >= 16'(TICK_CYCLES - 1)) begin
			s_d.tick_cnt = 16'h0000;
			s_d.tick     = 1'b1;
		end else begin
			s_d.tick_cnt = s_q.tick_cnt + 16'h0001;
		end

		// heater current monitor
		sel_out   = s_q.dout[hcm_cfg_in.chan];
		leak_cond = !sel_out && (heater_current_in > hcm_cfg_in.limit_low);
		miss_cond = sel_out && (heater_current_in < hcm_cfg_in.limit_high);
		if (hcm_cfg_in.latch) begin
			s_d.stat.heater_leak_current_alarm = leak_cond ||
				(s_q.stat.heater_leak_current_alarm && !host_in.alarm_acknowledge_bit);
			s_d.stat.heater_missing_current_alarm = miss_cond ||
				(s_q.stat.heater_missing_current_alarm && !host_in.alarm_acknowledge_bit);
		end else begin
			s_d.stat.heater_leak_current_alarm =
				leak_cond && !host_in.alarm_acknowledge_bit;
			s_d.stat.heater_missing_current_alarm =
				miss_cond && !host_in.alarm_acknowledge_bit;
		end

		// input fault
		if (fault_latch_in) begin
			s_d.stat.input_fault_alarm = input_fault_in ||
				(s_q.stat.input_fault_alarm && !host_in.fault_acknowledge_bit);
		end else begin
			s_d.stat.input_fault_alarm = input_fault_in;
		end
		fault_now = input_fault_in || s_q.stat.input_fault_alarm;
		s_d.stat.any_process_alarm = (|proc_alarm_in) || s_q.stat.input_fault_alarm;

		// auto-tune on/off decision
		gap     = 32'(setpoint_in) - 32'(pv_in);
		want_on = s_q.heat_on;
		if (32'(pv_in) < 32'(s_q.target) - $signed(32'({16'h0000, onoff_hyst_in}))) begin
			want_on = 1'b1;
		end else if (32'(pv_in) > 32'(s_q.target) + $signed(32'({16'h0000, onoff_hyst_in}))) begin
			want_on = 1'b0;
		end
		resp  = (tune_response_in > RESP_MAX) ? RESP_MAX : tune_response_in;
		swing = 32'(s_q.pmax - s_q.pmin) * 32'(RESP_BASE + 4'(resp));

		case (s_q.st)
			ST_IDLE: begin
				if (host_in.autotune_request) begin
					s_d.target = 16'(32'(pv_in) + (gap * 32'sd3) / 32'sd4);
					s_d.cyc_cnt = 3'h0;
					s_d.per_cnt = 16'h0000;
					s_d.pmax    = pv_in;
					s_d.pmin    = pv_in;
					if (fault_now) begin
						s_d.st = ST_DONE;
						s_d.stat.autotune_complete_flag = 1'b1;
						s_d.stat.autotune_error_flag    = 1'b1;
					end else begin
						s_d.st = ST_RUN;
						s_d.stat.autotune_running_ack = 1'b1;
						s_d.heat_on = 1'b0;
					end
				end
			end
			ST_RUN: begin
				if (!host_in.autotune_request) begin
					s_d.st = ST_IDLE;
					s_d.stat.autotune_running_ack = 1'b0;
				end else if (fault_now) begin
					s_d.st = ST_DONE;
					s_d.stat.autotune_running_ack   = 1'b0;
					s_d.stat.autotune_complete_flag = 1'b1;
					s_d.stat.autotune_error_flag    = 1'b1;
				end else begin
					s_d.heat_on = want_on;
					if (pv_in > s_q.pmax) begin
						s_d.pmax = pv_in;
					end
					if (pv_in < s_q.pmin) begin
						s_d.pmin = pv_in;
					end
					if (s_q.tick) begin
						s_d.per_cnt = s_q.per_cnt + 16'h0001;
					end
					if (want_on && !s_q.heat_on) begin
						s_d.per_cnt = 16'h0000;
						s_d.period  = s_q.per_cnt;
						s_d.cyc_cnt = s_q.cyc_cnt + 3'h1;
						if (s_q.cyc_cnt + 3'h1 >= TUNE_CYCLES) begin
							s_d.st      = ST_DONE;
							s_d.heat_on = 1'b0;
							s_d.pband   = swing[17:2];
							s_d.stat.autotune_running_ack   = 1'b0;
							s_d.stat.autotune_complete_flag = 1'b1;
						end
					end
				end
			end
			ST_DONE: begin
				if (!host_in.autotune_request) begin
					s_d.st = ST_IDLE;
					s_d.stat.autotune_running_ack   = 1'b0;
					s_d.stat.autotune_complete_flag = 1'b0;
					s_d.stat.autotune_error_flag    = 1'b0;
				end
			end
			default: begin
				s_d.st = ST_IDLE;
			end
		endcase

		// control output
		if (fault_now) begin
			s_d.ctrl = fault_value_in;
		end else if (s_q.st == ST_RUN) begin
			s_d.ctrl = s_q.heat_on ? $signed(FULL_SCALE) : 16'sh0;
		end else begin
			s_d.ctrl = pid_output_in;
		end

		// discrete outputs
		for (int i = 0; i < N_DOUT; i++) begin
			case (plt_dmap_t'(dout_map_in[2*i +: 2]))
				MAP_HEAT, MAP_COOL: begin
					s_d.dout[i] = tp_on[i];
				end
				MAP_ALARM: begin
					s_d.dout[i] = s_q.stat.any_process_alarm;
				end
				default: begin
					s_d.dout[i] = 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			s_q      <= '0;
			s_q.st   <= ST_IDLE;
			s_q.stat <= STAT_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign status_out         = s_q.stat;
	assign dout_out           = s_q.dout;
	assign control_output_out = s_q.ctrl;
	assign tune_target_out    = s_q.target;
	assign tuned_period_out   = s_q.period;
	assign tuned_pband_out    = s_q.pband;

endmodule : plt_top

// >>> verif/plt_host_model.sv
// host controller model driving the auto-tune request
module plt_host_model
	import plt_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       reset_n_in,
	input  wire plt_stat_t  status_in,
	input  wire logic       go_in,
	input  wire logic       abort_in,
	input  wire logic [3:0] delay_in,
	output logic            request_out
);
	logic [3:0] wait_q;
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			request_out <= 1'b0;
			wait_q      <= 4'h0;
		end else if (go_in) begin
			request_out <= 1'b1;
		end else if (abort_in) begin
			request_out <= 1'b0;
		end else if (request_out && status_in.autotune_complete_flag) begin
			wait_q <= wait_q + 4'h1;
			if (wait_q == delay_in) begin
				request_out <= 1'b0;
				wait_q      <= 4'h0;
			end
		end
	end
endmodule : plt_host_model

// >>> verif/plt_top_sva.sv
// port checker of the process loop block
module plt_top_sva
	import plt_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC
)
(
	input wire logic               clk_in,
	input wire logic               reset_n_in,
	input wire plt_host_t          host_in,
	input wire plt_hcm_cfg_t       hcm_cfg_in,
	input wire logic [15:0]        heater_current_in,
	input wire logic               input_fault_in,
	input wire logic               fault_latch_in,
	input wire logic signed [15:0] fault_value_in,
	input wire plt_stat_t          status_out,
	input wire logic [N_DOUT-1:0]  dout_out,
	input wire logic signed [15:0] control_output_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	chk_leak_set:
	assert property (!host_in.alarm_acknowledge_bit && !dout_out[hcm_cfg_in.chan]
		&& heater_current_in > hcm_cfg_in.limit_low |=> status_out.heater_leak_current_alarm)
		else $error("leak alarm missed");
	chk_miss_set:
	assert property (!host_in.alarm_acknowledge_bit && dout_out[hcm_cfg_in.chan]
		&& heater_current_in < hcm_cfg_in.limit_high
		|=> status_out.heater_missing_current_alarm)
		else $error("missing alarm missed");
	chk_latch_hold:
	assert property (hcm_cfg_in.latch && status_out.heater_leak_current_alarm
		&& !host_in.alarm_acknowledge_bit |=> status_out.heater_leak_current_alarm)
		else $error("latched alarm dropped");
	chk_ack_disable:
	assert property (!hcm_cfg_in.latch && host_in.alarm_acknowledge_bit
		|=> !status_out.heater_leak_current_alarm && !status_out.heater_missing_current_alarm)
		else $error("disabled alarm active");
	chk_fault_subst:
	assert property (input_fault_in |=> control_output_out == $past(fault_value_in))
		else $error("substitute output wrong");
	chk_any_alarm:
	assert property (status_out.input_fault_alarm |=> status_out.any_process_alarm)
		else $error("any alarm missed");
	chk_fault_follow:
	assert property (!fault_latch_in |=> status_out.input_fault_alarm == $past(input_fault_in))
		else $error("fault flag wrong");
	chk_tune_start:
	assert property ($rose(host_in.autotune_request) && !input_fault_in
		&& !status_out.input_fault_alarm && !status_out.autotune_complete_flag
		|=> status_out.autotune_running_ack)
		else $error("tune ack missed");
	chk_req_fall:
	assert property ($fell(host_in.autotune_request) |=> !status_out.autotune_running_ack
		&& !status_out.autotune_complete_flag && !status_out.autotune_error_flag)
		else $error("handshake flags kept");
	chk_done_drop:
	assert property ($fell(status_out.autotune_running_ack) && $past(host_in.autotune_request)
		|-> status_out.autotune_complete_flag)
		else $error("ack fell without done");
	chk_fault_abort:
	assert property (status_out.autotune_running_ack && input_fault_in
		|=> status_out.autotune_complete_flag && status_out.autotune_error_flag)
		else $error("tune fault not flagged");
endmodule : plt_top_sva
bind plt_top plt_top_sva #(.TICK_CYCLES(TICK_CYCLES)) u_plt_top_sva (.clk_in, .reset_n_in,
	.host_in, .hcm_cfg_in, .heater_current_in, .input_fault_in, .fault_latch_in,
	.fault_value_in, .status_out, .dout_out, .control_output_out);

// >>> verif/plt_top_tb.sv
// self-checking bench of the process loop block
module plt_top_tb
	import plt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {int s; logic [15:0] v;} plt_note_t;
	logic clk_in = 1'b0, reset_n_in = 1'b0, on;
	logic alm_ack = 0, flt_ack = 0, req, go = 0, abort = 0, fault = 0, flatch = 0;
	logic signed [15:0] fval = 0, pid = 0, pv = 0, ctl, tgt;
	logic [15:0]        cur = 0, lo, hi, cu, aout, ons, per, pbd;
	logic [2:0]         tresp = 3'h0;
	int                 pmx = 0, pmn = 0;
	logic [3:0]         palm = 0, dout;
	logic [7:0]         dmap = 0;
	plt_hcm_cfg_t       hcm = '0;
	plt_aout_cfg_t      acfg = '{SRC_OUT, 16'sh0000, 16'sh4E20, 16'h0000, 16'h03E8, 16'h0002};
	plt_host_t          host;
	plt_stat_t          st;
	plt_note_t          notes[$], nt;
	int                 failures = 0, samples_checked = 0;
	assign host = '{alm_ack, flt_ack, req};
	always #12.5 clk_in = ~clk_in;
	// simple plant: heats while drive is positive during tune, keeps its range
	always @(posedge clk_in) begin
		if (st.autotune_running_ack) begin
			pv <= (ctl > 0) ? pv + 1 : pv - 1;
			pmx = (pv > pmx) ? pv : pmx;
			pmn = (pv < pmn) ? pv : pmn;
		end
	end
	plt_top #(.TICK_CYCLES(4)) u_plt_top (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.host_in(host), .hcm_cfg_in(hcm), .heater_current_in(cur), .input_fault_in(fault),
		.fault_latch_in(flatch), .fault_value_in(fval), .pid_output_in(pid),
		.proc_alarm_in(palm), .pv_in(pv), .setpoint_in(16'sh0064), .onoff_hyst_in(16'h0004),
		.tune_response_in(tresp), .dout_map_in(dmap), .cycle_ticks_in(16'h000A),
		.aout_cfg_in(acfg), .status_out(st), .dout_out(dout), .control_output_out(ctl),
		.aout_out(aout), .tune_target_out(tgt), .tuned_period_out(per), .tuned_pband_out(pbd));
	plt_host_model u_plt_host_model (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.status_in(st), .go_in(go), .abort_in(abort), .delay_in(4'h3), .request_out(req));
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] pick(int s);
		case (s)
			0: pick = {9'h000, st};
			1: pick = ctl;
			2: pick = tgt;
			3: pick = {15'h0000, aout > 16'h15E0 && aout < 16'h2710};
			4: pick = aout;
			6: pick = ons;
			7: pick = pbd;
			8: pick = {15'h0000, per != 16'h0000};
			default: pick = {14'h0000, st.heater_leak_current_alarm,
				st.heater_missing_current_alarm};
		endcase
	endfunction : pick
	task automatic check(logic [15:0] seen, logic [15:0] want);
		samples_checked++;
		if (seen !== want) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check
	task automatic note(int s, logic [15:0] v);
		notes.push_back('{s, v});
	endtask : note
	task automatic tk(int n);
		repeat (n) @(posedge clk_in);
	endtask : tk
	task automatic await(int s, logic [15:0] m, logic [15:0] w);
		int k;
		k = 0;
		while ((pick(s) & m) !== w && k < 3000) begin
			@(posedge clk_in);
			k++;
		end
		if (k == 3000) failures++;
	endtask : await
	task automatic close_out();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out
	// compares every queued note, oldest first, against settled outputs
	always @(negedge clk_in) begin
		while (notes.size() > 0) begin
			nt = notes.pop_front();
			check(pick(nt.s), nt.v);
		end
	end
	initial begin
		repeat (60000) @(posedge clk_in);
		failures++;
		close_out();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(61348));
		tk(12);
		reset_n_in <= 1'b1;
		tk(2);
		note(0, 16'h0000);
		note(1, 16'h0000);
		dmap <= 8'hFF;
		for (int i = 0; i < 12; i++) begin
			on = !i[0];
			lo = 16'($urandom % 10001);
			hi = 16'($urandom % 10001);
			cu = 16'($urandom % 10001);
			hcm <= '{2'($urandom), lo, hi, 1'b0};
			cur <= cu;
			palm <= {4{on}};
			tk(5);
			note(5, {14'h0000, !on && cu > lo, on && cu < hi});
		end
		palm <= 4'h0;
		hcm <= '{2'h0, 16'h03E8, 16'h0000, 1'b1};
		cur <= 16'h07D0;
		tk(4);
		cur <= 16'h0000;
		tk(4);
		note(5, 16'h0002);
		alm_ack <= 1'b1;
		tk(3);
		note(5, 16'h0000);
		hcm.latch <= 1'b0;
		cur <= 16'h07D0;
		tk(3);
		note(5, 16'h0000);
		alm_ack <= 1'b0;
		tk(3);
		note(5, 16'h0002);
		cur <= 16'h0000;
		fval <= 16'sh4E20;
		fault <= 1'b1;
		tk(3);
		note(1, 16'h4E20);
		note(5, 16'h0000);
		note(0, 16'h0003);
		fault <= 1'b0;
		tk(3);
		note(0, 16'h0000);
		flatch <= 1'b1;
		fault <= 1'b1;
		tk(2);
		fault <= 1'b0;
		tk(3);
		note(0, 16'h0003);
		flt_ack <= 1'b1;
		tk(3);
		note(0, 16'h0000);
		flt_ack <= 1'b0;
		flatch <= 1'b0;
		for (int m = 1; m < 3; m++) begin
			dmap <= 8'(m);
			pid <= (m == 1) ? 16'sh1388 : 16'shEC78;
			tk(100);
			ons = 16'h0000;
			repeat (400) begin
				@(negedge clk_in);
				ons += dout[0];
			end
			note(6, 16'h00C8);
			tk(1);
		end
		note(4, 16'h0000);
		pid <= 16'sh2710;
		tk(60);
		note(4, 16'h1388);
		pid <= 16'sh2A30;
		tk(60);
		note(4, 16'h1388);
		pid <= 16'sh2BC0;
		tk(60);
		note(4, 16'h15E0);
		acfg.deadband <= 16'h0000;
		acfg.filt_s <= 16'h0001;
		pid <= 16'sh4E20;
		tk(200);
		note(3, 16'h0001);
		dmap <= 8'h00;
		tresp <= 3'($urandom % 5);
		go <= 1'b1;
		tk(1);
		go <= 1'b0;
		await(0, 16'h0040, 16'h0040);
		note(2, 16'h004B);
		await(0, 16'h0020, 16'h0020);
		note(0, 16'h0020);
		note(7, 16'(((pmx - pmn) * (int'(RESP_BASE) + int'(tresp))) / 4));
		note(8, 16'h0001);
		await(0, 16'h0020, 16'h0000);
		note(0, 16'h0000);
		for (int j = 0; j < 2; j++) begin
			go <= 1'b1;
			tk(1);
			go <= 1'b0;
			await(0, 16'h0040, 16'h0040);
			if (j == 0) begin
				abort <= 1'b1;
				tk(1);
				abort <= 1'b0;
				tk(2);
			end else begin
				fault <= 1'b1;
				tk(3);
				note(0, 16'h0033);
				fault <= 1'b0;
				await(0, 16'h0020, 16'h0000);
			end
			note(0, 16'h0000);
		end
		tk(2);
		close_out();
	end
endmodule : plt_top_tb
